/* rtl/pioc_params.svh */
`ifndef PIOC_PARAMS_SVH
`define PIOC_PARAMS_SVH
// register byte addresses, one per port per kind, global at its base only (port n at base + 4*n)
`define PIOC_ADDR_LATCH 12'h000
`define PIOC_ADDR_MODE_IN 12'h010
`define PIOC_ADDR_MODE_OUT 12'h020
`define PIOC_ADDR_DRIVE 12'h030
`define PIOC_ADDR_PINS 12'h040
`define PIOC_ADDR_GLOBAL 12'h050
`define PIOC_ADDR_KIND_MASK 12'hff0
`define PIOC_ADDR_PORT_LO 2
// port count and width
`define PIOC_NPORTS 3
`define PIOC_PORT_W 8
`define PIOC_NPINS 24
// reset values
`define PIOC_RST_LATCH 8'hff
`define PIOC_RST_MODE_IN 8'hff
`define PIOC_RST_MODE_OUT 8'h00
`define PIOC_RST_DRIVE 8'h00
`define PIOC_RST_PUD 1'b0
// pins withheld from general use: bits of port 1 (p1.0-p1.4)
`define PIOC_P1_RADIO_MASK 8'h17
`define PIOC_P1_UNAVAIL_MASK 8'h08
// index of pin shared with debug data line (p2.7)
`define PIOC_DBG_PIN 23
`endif

/* rtl/pioc_pkg.sv */
package pioc_pkg;
  // apb transfer phase of the slave
  typedef enum logic [1:0] {
    PIOC_IDLE = 2'b00,
    PIOC_SETUP = 2'b01,
    PIOC_ACCESS = 2'b10
  } pioc_phase_t;
  // register kind decoded from address
  typedef enum logic [2:0] {
    PIOC_K_LATCH = 3'b000,
    PIOC_K_MDIN = 3'b001,
    PIOC_K_MDOUT = 3'b010,
    PIOC_K_DRV = 3'b011,
    PIOC_K_PINS = 3'b100,
    PIOC_K_GLOBAL = 3'b101,
    PIOC_K_NONE = 3'b110
  } pioc_kind_t;
endpackage : pioc_pkg

/* rtl/pioc_sync.sv */
// two stage synchroniser for a bus of pad levels
module pioc_sync (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // raw and synchronised levels
  input wire logic [23:0] d_i,
  output logic [23:0] q_o
);
  // first stage, read only by the second
  logic [23:0] meta_q;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      meta_q <= 24'h000000;
      q_o <= 24'h000000;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule : pioc_sync

/* rtl/pioc_top.sv */
// Functional notes
// - select bit zero analog, one digital
// - reset: digital, high impedance, pull-up on
// - analog cell: no pull-up, no receiver
// - analog pin reads back zero
// - push-pull drives pad both ways
// - open-drain: low drive only, else off
// - high impedance digital cell gets pull-up
// - pull-up off while driving low
// - global disable kills all pull-ups
// - digital pin reads actual pad level
// - per-pin drive strength, low at reset
// - three byte ports, selectable analog pins
// - radio link pins reserved, p1.3 withheld
// - p2.7 gpio shared with debug data
`include "pioc_params.svh"
module pioc_top (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // peripheral overrides per pin
  input wire logic [23:0] periph_sel_i,
  input wire logic [23:0] periph_out_i,
  input wire logic [23:0] periph_oe_i,
  // debug data line sharing p2.7
  input wire logic dbg_own_i,
  input wire logic dbg_out_i,
  input wire logic dbg_oe_i,
  output logic dbg_in_o,
  // pads
  input wire logic [23:0] pad_i,
  output logic [23:0] pad_o,
  output logic [23:0] pad_oe_o,
  output logic [23:0] pad_pullup_o,
  output logic [23:0] pad_rx_en_o,
  output logic [23:0] pad_drive_high_o,
  // synchronised pin levels for internal peripherals
  output logic [23:0] pin_level_o
);
  // per-port configuration, stored flat, one byte per port
  logic [23:0] latch_q;
  logic [23:0] pin_analog_digital_select_q;
  logic [23:0] pin_output_mode_select_q;
  logic [23:0] pin_drive_strength_select_q;
  logic pullup_global_disable_q;
  // synchronised pad levels
  logic [23:0] pad_sync;
  // pin that general use may touch
  logic [23:0] usable;
  // output logic value and drive enables per pin
  logic [23:0] out_val;
  logic [23:0] drive_en;
  logic [23:0] pin_read;
  // decoded access
  pioc_pkg::pioc_kind_t kind;
  logic [1:0] port;
  logic wr_en;
  logic rd_en;

  // classify an address into its register kind
  function automatic pioc_pkg::pioc_kind_t decode_kind(
      input logic [11:0] a);
    logic [11:0] b;
    b = a & `PIOC_ADDR_KIND_MASK;
    if (a[`PIOC_ADDR_PORT_LO+1:`PIOC_ADDR_PORT_LO] == 2'h3 ||
        a[1:0] != 2'h0)
      decode_kind = pioc_pkg::PIOC_K_NONE;
    else if (b == `PIOC_ADDR_LATCH)
      decode_kind = pioc_pkg::PIOC_K_LATCH;
    else if (b == `PIOC_ADDR_MODE_IN)
      decode_kind = pioc_pkg::PIOC_K_MDIN;
    else if (b == `PIOC_ADDR_MODE_OUT)
      decode_kind = pioc_pkg::PIOC_K_MDOUT;
    else if (b == `PIOC_ADDR_DRIVE)
      decode_kind = pioc_pkg::PIOC_K_DRV;
    else if (b == `PIOC_ADDR_PINS)
      decode_kind = pioc_pkg::PIOC_K_PINS;
    else if (a == `PIOC_ADDR_GLOBAL)
      decode_kind = pioc_pkg::PIOC_K_GLOBAL;
    else
      decode_kind = pioc_pkg::PIOC_K_NONE;
  endfunction : decode_kind

  // merge a byte into one port lane of a flat vector
  function automatic logic [23:0] put_byte(input logic [23:0] v,
      input logic [1:0] p, input logic [7:0] d);
    logic [23:0] r;
    r = v;
    r[p*8 +: 8] = d;
    put_byte = r;
  endfunction : put_byte

  // pins withheld from general use: radio link and p1.3
  assign usable = ~{8'h00,
      (`PIOC_P1_RADIO_MASK | `PIOC_P1_UNAVAIL_MASK), 8'h00};

  // every transfer answers in its first access cycle
  assign kind = decode_kind(paddr_i);
  assign port = paddr_i[`PIOC_ADDR_PORT_LO+1:`PIOC_ADDR_PORT_LO];
  assign pready_o = psel_i & penable_i;
  assign pslverr_o = psel_i & penable_i &
      (kind == pioc_pkg::PIOC_K_NONE);
  assign wr_en = psel_i & penable_i & pwrite_i &
      (kind != pioc_pkg::PIOC_K_NONE);
  assign rd_en = psel_i & ~penable_i & ~pwrite_i;

  // output latches, all ones at reset so nothing drives low
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      latch_q <= {3{`PIOC_RST_LATCH}};
    end else if (wr_en && kind == pioc_pkg::PIOC_K_LATCH) begin
      latch_q <= put_byte(latch_q, port, pwdata_i[7:0]);
    end
  end

  // analog or digital select, digital at reset
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pin_analog_digital_select_q <= {3{`PIOC_RST_MODE_IN}};
    end else if (wr_en && kind == pioc_pkg::PIOC_K_MDIN) begin
      pin_analog_digital_select_q <= put_byte(
          pin_analog_digital_select_q, port, pwdata_i[7:0]);
    end
  end

  // output mode, open-drain at reset so the pad floats
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pin_output_mode_select_q <= {3{`PIOC_RST_MODE_OUT}};
    end else if (wr_en && kind == pioc_pkg::PIOC_K_MDOUT) begin
      pin_output_mode_select_q <= put_byte(
          pin_output_mode_select_q, port, pwdata_i[7:0]);
    end
  end

  // drive strength, low at reset
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pin_drive_strength_select_q <= {3{`PIOC_RST_DRIVE}};
    end else if (wr_en && kind == pioc_pkg::PIOC_K_DRV) begin
      pin_drive_strength_select_q <= put_byte(
          pin_drive_strength_select_q, port, pwdata_i[7:0]);
    end
  end

  // global pull-up disable
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pullup_global_disable_q <= `PIOC_RST_PUD;
    end else if (wr_en && kind == pioc_pkg::PIOC_K_GLOBAL) begin
      pullup_global_disable_q <= pwdata_i[0];
    end
  end

  // pad level synchroniser
  pioc_sync u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .d_i(pad_i),
    .q_o(pad_sync)
  );

  // per-pin cell logic
  genvar gi;
  generate
    for (gi = 0; gi < `PIOC_NPINS; gi++) begin : g_cell
      logic dbg_here;
      logic pp;
      logic en_raw;
      // debug owns the shared pad only on p2.7
      assign dbg_here = (gi == `PIOC_DBG_PIN) & dbg_own_i;
      assign pp = pin_output_mode_select_q[gi];
      // output value: debug, then peripheral, then latch
      assign out_val[gi] = dbg_here ? dbg_out_i :
          periph_sel_i[gi] ? periph_out_i[gi] : latch_q[gi];
      // a peripheral may release its pin with its own enable
      assign en_raw = dbg_here ? dbg_oe_i :
          (periph_sel_i[gi] ? periph_oe_i[gi] : 1'b1);
      // push-pull drives both levels, open-drain only low
      assign drive_en[gi] = en_raw & usable[gi] &
          (pp | ~out_val[gi]) & (dbg_here |
          pin_analog_digital_select_q[gi]);
      assign pad_oe_o[gi] = drive_en[gi];
      assign pad_o[gi] = out_val[gi];
      // pull-up only when digital, not driving low, not disabled
      assign pad_pullup_o[gi] = pin_analog_digital_select_q[gi] &
          ~(drive_en[gi] & ~out_val[gi]) &
          ~pullup_global_disable_q;
      assign pad_rx_en_o[gi] = pin_analog_digital_select_q[gi];
      assign pad_drive_high_o[gi] =
          pin_drive_strength_select_q[gi];
      // analog pins read zero, digital read the pad
      assign pin_read[gi] = pad_sync[gi] &
          pin_analog_digital_select_q[gi];
    end
  endgenerate

  assign pin_level_o = pin_read;
  // debug receiver sees p2.7 regardless of general-use config
  assign dbg_in_o = pad_sync[`PIOC_DBG_PIN];

  // read data captured in setup so it is stable in access
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      prdata_o <= 32'h00000000;
    end else if (rd_en) begin
      unique case (kind)
        pioc_pkg::PIOC_K_LATCH:
          prdata_o <= {24'h000000, latch_q[port*8 +: 8]};
        pioc_pkg::PIOC_K_MDIN:
          prdata_o <= {24'h000000,
              pin_analog_digital_select_q[port*8 +: 8]};
        pioc_pkg::PIOC_K_MDOUT:
          prdata_o <= {24'h000000,
              pin_output_mode_select_q[port*8 +: 8]};
        pioc_pkg::PIOC_K_DRV:
          prdata_o <= {24'h000000,
              pin_drive_strength_select_q[port*8 +: 8]};
        pioc_pkg::PIOC_K_PINS:
          prdata_o <= {24'h000000, pin_read[port*8 +: 8]};
        pioc_pkg::PIOC_K_GLOBAL:
          prdata_o <= {31'h00000000, pullup_global_disable_q};
        default:
          prdata_o <= 32'h00000000;
      endcase
    end
  end

  // assertions
  a_analog_no_pull: assert property (@(posedge sys_clk_i)
      disable iff (rst_i)
      (~pin_analog_digital_select_q[0] |-> ~pad_pullup_o[0] &&
      ~pad_rx_en_o[0]))
    else $error("analog cell has pull-up or receiver");
  a_analog_reads_zero: assert property (@(posedge sys_clk_i)
      disable iff (rst_i)
      (~pin_analog_digital_select_q[1] |-> ~pin_read[1]))
    else $error("analog pin read nonzero");
  a_od_no_high: assert property (@(posedge sys_clk_i)
      disable iff (rst_i)
      (pad_oe_o[2] && ~pin_output_mode_select_q[2] &&
      ~periph_sel_i[2] |-> ~pad_o[2]))
    else $error("open-drain drives high");
  a_pp_drives: assert property (@(posedge sys_clk_i)
      disable iff (rst_i)
      (pin_output_mode_select_q[0] && pin_analog_digital_select_q[0]
      && ~periph_sel_i[0] |-> pad_oe_o[0] &&
      pad_o[0] == latch_q[0]))
    else $error("push-pull pin not driven from latch");
  a_pull_off_low: assert property (@(posedge sys_clk_i)
      disable iff (rst_i)
      (pad_oe_o[4] && ~pad_o[4] |-> ~pad_pullup_o[4]))
    else $error("pull-up on while driving low");
  a_global_pud: assert property (@(posedge sys_clk_i)
      disable iff (rst_i)
      (pullup_global_disable_q |-> pad_pullup_o == 24'h000000))
    else $error("pull-up on under global disable");
  // the synchroniser restarts from zero, so skip two cycles after reset
  a_read_sync: assert property (@(posedge sys_clk_i)
      disable iff (rst_i)
      (!$past(rst_i) && !$past(rst_i, 2) &&
      pin_analog_digital_select_q[5] &&
      $stable(pin_analog_digital_select_q[5])
      |-> pin_read[5] == $past(pad_i[5], 2)))
    else $error("pin read not two-stage pad level");
  a_reserved_idle: assert property (@(posedge sys_clk_i)
      disable iff (rst_i)
      (pad_oe_o[11:8] == 4'h0 && pad_oe_o[12] == 1'b0))
    else $error("reserved pin driven");
  a_reset_state: assert property (@(posedge sys_clk_i)
      $past(rst_i) && !rst_i |-> pad_oe_o[0] == 1'b0 &&
      pad_pullup_o[0] && pad_rx_en_o[0])
    else $error("bad state after reset");
  // an undriven digital cell gets its pull-up unless pull-ups are globally disabled
  a_hiz_pullup: assert property (@(posedge sys_clk_i)
      disable iff (rst_i)
      (pin_analog_digital_select_q[6] && ~pad_oe_o[6] &&
      ~pullup_global_disable_q |-> pad_pullup_o[6]))
    else $error("floating digital cell lacks pull-up");
  // debug owner drives the shared pad when its mode allows
  a_dbg_drives: assert property (@(posedge sys_clk_i)
      disable iff (rst_i)
      (dbg_own_i && dbg_oe_i && pin_output_mode_select_q[23]
      |-> pad_oe_o[23] && pad_o[23] == dbg_out_i))
    else $error("debug line not driven on shared pad");
  c_write_cfg: cover property (@(posedge sys_clk_i)
      wr_en && kind == pioc_pkg::PIOC_K_MDOUT);
  c_analog_pin: cover property (@(posedge sys_clk_i)
      ~pin_analog_digital_select_q[3]);
  c_dbg_own: cover property (@(posedge sys_clk_i)
      dbg_own_i && pad_oe_o[23]);
  c_pin_read: cover property (@(posedge sys_clk_i)
      rd_en && kind == pioc_pkg::PIOC_K_PINS);
endmodule : pioc_top

/* verification/pioc_pad_model.sv */
// outside world at the pads: resolves what each pad line really carries
module pioc_pad_model (
  // clock
  input wire logic clk_i,
  // device side of the cells
  input wire logic [23:0] out_i,
  input wire logic [23:0] oe_i,
  input wire logic [23:0] pu_i,
  // external circuit drive
  input wire logic [23:0] ext_en_i,
  input wire logic [23:0] ext_val_i,
  // resolved pad level
  output logic [23:0] pad_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // a floating line wanders every cycle, so no level is trusted there
  logic [23:0] noise_q = 24'h5a3c96;
  always_ff @(posedge clk_i) begin
    noise_q <= ~noise_q;
  end
  // device drive wins, then outside drive, then weak pull-up
  always_comb begin
    for (int i = 0; i < 24; i++) begin
      pad_o[i] = oe_i[i] ? out_i[i] : ext_en_i[i] ? ext_val_i[i] :
        pu_i[i] ? 1'b1 : noise_q[i];
    end
  end
endmodule : pioc_pad_model

/* verification/tb.sv */
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
  miscompares++; $display("mismatch t=%0t got=%h exp=%h", $time, a, b); \
  end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // dut stimulus and observation
  logic sys_clk_i, rst_i, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [23:0] sel, pout, poe, ext_en, ext_val;
  logic dbg_own, dbg_out, dbg_oe, dbg_in;
  logic [23:0] pad_i, pad_o, pad_oe, pad_pu, pad_rx, pad_dh, pin_lvl;
  int miscompares = 0;
  int n_compared = 0;
  // reference state: [kind][port], kinds latch/select/mode/drive
  int cfg[4][3];
  int pud;
  pioc_top dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .periph_sel_i(sel), .periph_out_i(pout),
    .periph_oe_i(poe), .dbg_own_i(dbg_own), .dbg_out_i(dbg_out),
    .dbg_oe_i(dbg_oe), .dbg_in_o(dbg_in), .pad_i(pad_i), .pad_o(pad_o),
    .pad_oe_o(pad_oe), .pad_pullup_o(pad_pu), .pad_rx_en_o(pad_rx),
    .pad_drive_high_o(pad_dh), .pin_level_o(pin_lvl));
  pioc_pad_model pads (.clk_i(sys_clk_i), .out_i(pad_o), .oe_i(pad_oe),
    .pu_i(pad_pu), .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_o(pad_i));
  // 250 MHz clock
  initial begin
    sys_clk_i = 0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  // verdict and end of run
  task automatic final_report();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  // one apb transfer, entered right after a rising edge
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [7:0] d, output logic [31:0] rd, output logic err);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge sys_clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (n >= 50) begin
      miscompares++;
      final_report();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk_i);
  endtask : apb
  // compare every cell output and register with the reference
  task automatic check_all();
    logic [23:0] md, eo, ev, epu, lvl;
    logic [31:0] rd;
    logic er, v, en;
    int p, b;
    for (int i = 0; i < 24; i++) begin
      p = i / 8;
      b = i % 8;
      md[i] = cfg[1][p][b];
      v = sel[i] ? pout[i] : cfg[0][p][b];
      en = sel[i] ? poe[i] : 1'b1;
      eo[i] = md[i] && en && (cfg[2][p][b] || !v) && !(i >= 8 && i <= 12);
      ev[i] = cfg[2][p][b] ? v : 1'b0;
      if (i == 23 && dbg_own) begin
        // output mode still applies: open-drain never drives high
        eo[i] = dbg_oe && (cfg[2][p][b] || !dbg_out);
        ev[i] = dbg_out;
      end
      epu[i] = md[i] && pud == 0 && !(eo[i] && !ev[i]);
      lvl[i] = eo[i] ? ev[i] : ext_en[i] ? ext_val[i] : epu[i];
    end
    `CHK(pad_oe, eo)
    `CHK(pad_o & eo, ev & eo)
    `CHK(pad_pu | {dbg_own, 23'h0}, epu | {dbg_own, 23'h0})
    `CHK(pad_rx, md)
    `CHK(pin_lvl, lvl & md)
    `CHK(dbg_in, lvl[23])
    for (int q = 0; q < 3; q++) begin
      `CHK(pad_dh[q*8+:8], cfg[3][q][7:0])
      apb(1'b0, 12'(64 + 4 * q), 8'h0, rd, er);
      `CHK({er, rd}, {25'h0, lvl[q*8+:8] & md[q*8+:8]})
      for (int k = 0; k < 4; k++) begin
        apb(1'b0, 12'(16 * k + 4 * q), 8'h0, rd, er);
        `CHK({er, rd}, {25'h0, cfg[k][q][7:0]})
      end
    end
    apb(1'b0, 12'h050, 8'h0, rd, er);
    `CHK({er, rd}, {32'h0, pud[0]})
  endtask : check_all
  // stall guard
  initial begin
    repeat (100000) @(posedge sys_clk_i);
    miscompares++;
    final_report();
  end
  // main sequence
  initial begin
    logic [31:0] rd;
    logic er;
    rst_i = 1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {sel, pout, poe, ext_en, ext_val, dbg_own, dbg_out, dbg_oe} = '0;
    void'($urandom(32'hd5c6));
    for (int q = 0; q < 3; q++) begin
      cfg[0][q] = 255;
      cfg[1][q] = 255;
      cfg[2][q] = 0;
      cfg[3][q] = 0;
    end
    pud = 0;
    repeat (16) @(posedge sys_clk_i);
    rst_i <= 0;
    repeat (4) @(posedge sys_clk_i);
    check_all();
    for (int it = 0; it < 25; it++) begin
      for (int q = 0; q < 3; q++) begin
        cfg[1][q] = $urandom % 256;
        cfg[0][q] = ($urandom | ~cfg[1][q]) % 256;
        cfg[2][q] = $urandom & cfg[1][q] & 255;
        cfg[3][q] = $urandom % 256;
        for (int k = 0; k < 4; k++) begin
          apb(1'b1, 12'(16 * k + 4 * q), 8'(cfg[k][q]), rd, er);
        end
      end
      pud = ($urandom % 4 == 0);
      apb(1'b1, 12'h050, 8'(pud), rd, er);
      apb(1'b1, 12'h044, 8'h5a, rd, er);
      `CHK(er, 1'b0)
      sel <= 24'($urandom) &
          {cfg[1][2][7:0], cfg[1][1][7:0], cfg[1][0][7:0]};
      pout <= 24'($urandom);
      poe <= 24'($urandom);
      dbg_own <= (it % 5 == 4);
      {dbg_out, dbg_oe} <= 2'($urandom);
      ext_val <= 24'($urandom);
      // p2.7 is read unmasked by debug, so it is never left floating
      ext_en <= (pud != 0 || it % 5 == 4) ? '1 :
          (24'($urandom) | 24'h800000);
      repeat (4) @(posedge sys_clk_i);
      check_all();
    end
    apb(1'b1, 12'h00c, 8'h00, rd, er);
    `CHK(er, 1'b1)
    apb(1'b0, 12'h001, 8'h0, rd, er);
    `CHK({er, rd}, {1'b1, 32'h0})
    check_all();
    final_report();
  end
endmodule : tb
